// File: include/host_io_pkg.sv
package host_io_pkg;

    // host register-select codes
    localparam logic [1:0] SEL_ADDR_LO  = 2'h0;
    localparam logic [1:0] SEL_ADDR_HI  = 2'h1;
    localparam logic [1:0] SEL_DATA     = 2'h2;
    localparam logic [1:0] SEL_DATA_INC = 2'h3;

    // writing this to the address-high byte resets the pointer, read data and every internal register
    localparam logic [7:0] HW_RESET_CMD = 8'h40;

    // internal register space behind the pointer
    localparam int          REG_IDX_W   = 4;
    localparam int          REG_DEPTH   = 16;
    localparam logic [15:0] REG_LIMIT   = 16'h0010;
    localparam logic [15:0] ADDR_RESET  = 16'h0000;
    localparam logic [7:0]  REG_RESET   = 8'h00;
    localparam logic [7:0]  RDATA_RESET = 8'h00;

    // serial I/O control register and its fields
    localparam logic [3:0]  CTRL_IDX           = 4'hA;
    localparam int          CTRL_EN_BIT        = 0;
    localparam int          CTRL_MDATA_OUT_BIT = 1;
    localparam int          CTRL_MDATA_DRV_BIT = 2;
    localparam int          CTRL_PHY_RST_BIT   = 3;
    localparam int          CTRL_MDATA_IN_BIT  = 4;
    localparam int          CTRL_EEP_CLK_BIT   = 5;
    localparam int          CTRL_EDATA_LOW_BIT = 6;
    localparam int          CTRL_EDATA_IN_BIT  = 7;

    // pin synchroniser vector layout
    localparam int          SYNC_W       = 14;
    localparam int          SYNC_SEL_N   = 13;
    localparam int          SYNC_RNW     = 12;
    localparam int          SYNC_RS_HI   = 11;
    localparam int          SYNC_RS_LO   = 10;
    localparam int          SYNC_BUS_HI  = 9;
    localparam int          SYNC_BUS_LO  = 2;
    localparam int          SYNC_MDATA   = 1;
    localparam int          SYNC_EDATA   = 0;
    localparam logic [13:0] SYNC_RESET   = 14'h2000;

    // management clock: clk_sys 40 MHz, half period in cycles
    localparam int          CLK_SYS_MHZ     = 40;
    localparam int          MCLK_HALF_NS    = 100;
    localparam int          MCLK_HALF_CYC   = (MCLK_HALF_NS * CLK_SYS_MHZ) / 1000;
    localparam logic [2:0]  MCLK_LAST       = 3'(MCLK_HALF_CYC - 1);
    localparam logic [2:0]  MCLK_CNT_RESET  = 3'h0;

    // shortest reset pulse that the core honours
    localparam int          RESET_MIN_US    = 3;
    localparam int          RESET_MIN_CYC   = RESET_MIN_US * CLK_SYS_MHZ;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETTLE,
        ST_DONE
    } port_state_t;

endpackage

// File: src/sync_2ff.sv
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
    parameter int               WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] hold_q;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_q <= RESET_VALUE;
            hold_q <= RESET_VALUE;
        end
        else
        begin
            meta_q <= async_in;
            hold_q <= meta_q;
        end
    end

    assign sync_out = hold_q;
endmodule
`default_nettype wire

// File: src/host_io_port.sv
`timescale 1ns/1ps
`default_nettype none
module host_io_port
    import host_io_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       port_select_n,
    input  wire logic       host_read_not_write,
    input  wire logic       register_select_hi,
    input  wire logic       register_select_lo,
    input  wire logic [7:0] host_bus_in,
    output logic      [7:0] host_bus_out,
    output logic            host_bus_oe,
    output logic            host_ready_n,
    output logic            host_ready_oe,
    output logic            mgmt_serial_clock,
    output logic            mgmt_serial_clock_oe,
    input  wire logic       mgmt_data_in,
    output logic            mgmt_data_out,
    output logic            mgmt_data_oe,
    output logic            mgmt_phy_reset,
    output logic            mgmt_phy_reset_oe,
    output logic            eeprom_clock,
    input  wire logic       eeprom_data_in,
    output logic            eeprom_data_out,
    output logic            eeprom_data_oe
);
    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_out;
    logic              sel_s;
    logic              rnw_s;
    logic [1:0]        rsel_s;
    logic [7:0]        wdata_s;
    logic              mdata_s;
    logic              edata_s;

    port_state_t       state_q;
    port_state_t       state_d;
    logic [15:0]       addr_q;
    logic [15:0]       addr_d;
    logic [7:0]        rdata_q;
    logic [7:0]        rdata_d;
    logic [7:0]        regs_q [REG_DEPTH];
    logic [7:0]        regs_d [REG_DEPTH];
    logic              access;
    logic              hw_reset;
    logic [2:0]        mclk_cnt_q;
    logic [2:0]        mclk_cnt_d;
    logic              mclk_q;
    logic              mclk_d;
    logic              mgmt_en;
    logic [7:0]        ctrl_q;

    // every host pin, data included, crosses on two flops
    assign sync_in = {port_select_n, host_read_not_write, register_select_hi,
                      register_select_lo, host_bus_in, mgmt_data_in, eeprom_data_in};

    sync_2ff #(
        .WIDTH       (SYNC_W),
        .RESET_VALUE (SYNC_RESET)
    ) u_sync (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .async_in (sync_in),
        .sync_out (sync_out)
    );

    assign sel_s   = !sync_out[SYNC_SEL_N];
    assign rnw_s   = sync_out[SYNC_RNW];
    assign rsel_s  = {sync_out[SYNC_RS_HI], sync_out[SYNC_RS_LO]};
    assign wdata_s = sync_out[SYNC_BUS_HI:SYNC_BUS_LO];
    assign mdata_s = sync_out[SYNC_MDATA];
    assign edata_s = sync_out[SYNC_EDATA];

    assign ctrl_q  = regs_q[CTRL_IDX];
    assign mgmt_en = ctrl_q[CTRL_EN_BIT];

    function automatic logic reg_hit(input logic [15:0] addr);
        reg_hit = (addr < REG_LIMIT);
    endfunction

    function automatic logic [7:0] reg_read(input logic [15:0] addr);
        logic [7:0] v;
        v = REG_RESET;
        if (reg_hit(addr))
        begin
            v = regs_q[addr[REG_IDX_W-1:0]];
            // input bits of the control register show the pins, not storage
            if (addr[REG_IDX_W-1:0] == CTRL_IDX)
            begin
                v[CTRL_MDATA_IN_BIT] = mdata_s;
                v[CTRL_EDATA_IN_BIT] = edata_s;
            end
        end
        reg_read = v;
    endfunction

    always_comb
    begin
        state_d  = state_q;
        addr_d   = addr_q;
        rdata_d  = rdata_q;
        regs_d   = regs_q;
        access   = 1'b0;
        hw_reset = 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                if (sel_s)
                    state_d = ST_SETTLE;
            end
            // one cycle lets all synced pins agree before acting
            ST_SETTLE:
            begin
                if (!sel_s)
                    state_d = ST_IDLE;
                else
                begin
                    access  = 1'b1;
                    state_d = ST_DONE;
                    if (rnw_s)
                    begin
                        case (rsel_s)
                            SEL_ADDR_LO: rdata_d = addr_q[7:0];
                            SEL_ADDR_HI: rdata_d = addr_q[15:8];
                            default:     rdata_d = reg_read(addr_q);
                        endcase
                    end
                    else
                    begin
                        case (rsel_s)
                            SEL_ADDR_LO: addr_d[7:0] = wdata_s;
                            SEL_ADDR_HI:
                            begin
                                if (wdata_s == HW_RESET_CMD)
                                    hw_reset = 1'b1;
                                else
                                    addr_d[15:8] = wdata_s;
                            end
                            default:
                            begin
                                if (reg_hit(addr_q))
                                    regs_d[addr_q[REG_IDX_W-1:0]] = wdata_s;
                            end
                        endcase
                    end
                    if (rsel_s == SEL_DATA_INC)
                        addr_d = addr_q + 16'h0001;
                end
            end
            ST_DONE:
            begin
                if (!sel_s)
                    state_d = ST_IDLE;
            end
            default:
                state_d = ST_IDLE;
        endcase
        if (hw_reset)
        begin
            addr_d  = ADDR_RESET;
            rdata_d = RDATA_RESET;
            for (int i = 0; i < REG_DEPTH; i++)
                regs_d[i] = REG_RESET;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= ST_IDLE;
            addr_q  <= ADDR_RESET;
            rdata_q <= RDATA_RESET;
            for (int i = 0; i < REG_DEPTH; i++)
                regs_q[i] <= REG_RESET;
        end
        else
        begin
            state_q <= state_d;
            addr_q  <= addr_d;
            rdata_q <= rdata_d;
            regs_q  <= regs_d;
        end
    end

    // free-running divider; only its pin drive is gated
    always_comb
    begin
        mclk_cnt_d = mclk_cnt_q + 3'h1;
        mclk_d     = mclk_q;
        if (mclk_cnt_q == MCLK_LAST)
        begin
            mclk_cnt_d = MCLK_CNT_RESET;
            mclk_d     = !mclk_q;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            mclk_cnt_q <= MCLK_CNT_RESET;
            mclk_q     <= 1'b0;
        end
        else
        begin
            mclk_cnt_q <= mclk_cnt_d;
            mclk_q     <= mclk_d;
        end
    end

    // ready tri-state follows the synced select, so it lags the pin by two clocks
    assign host_ready_oe = sel_s;
    // ready rises with the synced deselect, not one clock later
    assign host_ready_n  = !((state_q == ST_DONE) && sel_s);
    assign host_bus_out  = rdata_q;
    assign host_bus_oe   = (state_q == ST_DONE) && sel_s && rnw_s;

    assign mgmt_serial_clock    = mclk_q;
    assign mgmt_serial_clock_oe = mgmt_en;
    assign mgmt_data_out        = ctrl_q[CTRL_MDATA_OUT_BIT];
    assign mgmt_data_oe         = mgmt_en && ctrl_q[CTRL_MDATA_DRV_BIT];
    assign mgmt_phy_reset       = ctrl_q[CTRL_PHY_RST_BIT];
    assign mgmt_phy_reset_oe    = mgmt_en;
    // eeprom data is open drain, only ever pulled low; the eeprom clock is driven directly
    assign eeprom_clock         = ctrl_q[CTRL_EEP_CLK_BIT];
    assign eeprom_data_out      = 1'b0;
    assign eeprom_data_oe       = ctrl_q[CTRL_EDATA_LOW_BIT];

    localparam int MCLK_WAIT = 4;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    sequence s_taken;
        (state_q == ST_SETTLE) && sel_s;
    endsequence

    sequence s_inc_taken;
        s_taken ##0 (rsel_s == SEL_DATA_INC);
    endsequence

    property p_read_ready;
        (!host_ready_n && rnw_s && sel_s) |-> host_bus_oe && (host_bus_out == rdata_q);
    endproperty
    a_read_ready: assert property (p_read_ready)
        else $error("ready low on read without driven data");

    property p_write_capture;
        (s_taken ##0 (!rnw_s && rsel_s == SEL_ADDR_LO)) |=>
            !host_ready_n && (addr_q[7:0] == $past(wdata_s));
    endproperty
    a_write_capture: assert property (p_write_capture)
        else $error("write ready without captured byte");

    property p_ready_float;
        !sel_s |-> !host_ready_oe && !host_bus_oe;
    endproperty
    a_ready_float: assert property (p_ready_float)
        else $error("ready driven while deselected");

    property p_mclk_runs;
        mgmt_en |-> ##[1:MCLK_WAIT] $changed(mgmt_serial_clock);
    endproperty
    a_mclk_runs: assert property (p_mclk_runs)
        else $error("management clock stalled");

    property p_mgmt_float;
        !mgmt_en |-> !mgmt_serial_clock_oe && !mgmt_data_oe && !mgmt_phy_reset_oe;
    endproperty
    a_mgmt_float: assert property (p_mgmt_float)
        else $error("management pins driven while disabled");

    property p_auto_inc;
        (s_inc_taken ##0 !(rnw_s == 1'b0 && hw_reset)) |=> addr_q == $past(addr_q) + 16'h0001;
    endproperty
    a_auto_inc: assert property (p_auto_inc)
        else $error("pointer did not advance by one");

    property p_ready_release;
        $fell(sel_s) |-> host_ready_n ##1 (host_ready_n && state_q == ST_IDLE);
    endproperty
    a_ready_release: assert property (p_ready_release)
        else $error("ready not released on deselect");

    property p_ready_wait;
        $rose(sel_s) |-> host_ready_n [*2] ##1 (!host_ready_n || !sel_s);
    endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("ready timing after select wrong");

    property p_bus_read_only;
        host_bus_oe |-> sel_s && rnw_s && ($past(state_q) != ST_IDLE);
    endproperty
    a_bus_read_only: assert property (p_bus_read_only)
        else $error("bus driven outside a read");
endmodule
`default_nettype wire

// File: sim/host_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] host_bus_out,
    input  wire logic       host_bus_oe,
    input  wire logic       host_ready_n,
    input  wire logic       host_ready_oe,
    output logic            port_select_n,
    output logic            host_read_not_write,
    output logic            register_select_hi,
    output logic            register_select_lo,
    output logic      [7:0] host_bus_in
);
    logic       drive_en;
    logic [7:0] drive_val;
    logic [7:0] last_val;
    logic       ready_pin;

    // pull-up keeps a floating ready inactive
    assign ready_pin = host_ready_oe ? host_ready_n : 1'b1;
    // an undriven bus shows the inverse of its last level
    assign host_bus_in = host_bus_oe ? host_bus_out : (drive_en ? drive_val : ~last_val);

    initial
    begin
        port_select_n = 1'b1;
        host_read_not_write = 1'b1;
        register_select_hi = 1'b0;
        register_select_lo = 1'b0;
        drive_en = 1'b0;
        drive_val = 8'h00;
        last_val = 8'h00;
    end

    always @(posedge clk_sys)
        last_val <= host_bus_in;

    // hold > 0 drops select early and expects no answer
    task automatic access(input logic rnw, input logic [1:0] sel, input logic [7:0] wdata,
                          input int hold, output logic [7:0] rdata, output logic ok);
        int n;
        ok = 1'b0;
        rdata = 8'h00;
        @(posedge clk_sys);
        port_select_n <= 1'b0;
        host_read_not_write <= rnw;
        {register_select_hi, register_select_lo} <= sel;
        drive_en <= ~rnw;
        drive_val <= wdata;
        for (n = 0; n < 16; n++)
        begin
            @(posedge clk_sys);
            if (ready_pin === 1'b0)
            begin
                rdata = host_bus_in;
                ok = (hold == 0);
                break;
            end
            if (hold != 0 && n + 1 >= hold)
            begin
                ok = 1'b1;
                break;
            end
        end
        port_select_n <= 1'b1;
        drive_en <= 1'b0;
        // select high long enough for the synchroniser to see it
        repeat (4) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// File: sim/test_host_io_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_host_io_port;
    import host_io_pkg::*;
    logic       clk_sys;
    logic       resetn;
    logic       port_select_n;
    logic       host_read_not_write;
    logic       register_select_hi;
    logic       register_select_lo;
    logic [7:0] host_bus_in;
    logic [7:0] host_bus_out;
    logic       host_bus_oe;
    logic       host_ready_n;
    logic       host_ready_oe;
    logic       mgmt_serial_clock;
    logic       mgmt_serial_clock_oe;
    logic       mgmt_data_in;
    logic       mgmt_data_out;
    logic       mgmt_data_oe;
    logic       mgmt_phy_reset;
    logic       mgmt_phy_reset_oe;
    logic       eeprom_clock;
    logic       eeprom_data_in;
    logic       eeprom_data_out;
    logic       eeprom_data_oe;
    int         errors;
    int         total_checks;
    int         i;

    // both serial data lines have pull-ups
    assign mgmt_data_in = mgmt_data_oe ? mgmt_data_out : 1'b1;
    assign eeprom_data_in = eeprom_data_oe ? eeprom_data_out : 1'b1;

    host_io_port dut (
        .clk_sys, .resetn, .port_select_n, .host_read_not_write,
        .register_select_hi, .register_select_lo, .host_bus_in, .host_bus_out,
        .host_bus_oe, .host_ready_n, .host_ready_oe, .mgmt_serial_clock,
        .mgmt_serial_clock_oe, .mgmt_data_in, .mgmt_data_out, .mgmt_data_oe,
        .mgmt_phy_reset, .mgmt_phy_reset_oe, .eeprom_clock, .eeprom_data_in,
        .eeprom_data_out, .eeprom_data_oe
    );

    host_cpu_model host (
        .clk_sys, .host_bus_out, .host_bus_oe, .host_ready_n, .host_ready_oe,
        .port_select_n, .host_read_not_write, .register_select_hi,
        .register_select_lo, .host_bus_in
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
        end
    endtask

    task automatic finish_access(input logic ok);
        check({7'h00, ok}, 8'h01);
        check({6'h00, host_ready_oe, host_bus_oe}, 8'h00);
        if (ok !== 1'b1)
            end_of_test();
    endtask

    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        logic [7:0] r;
        logic       ok;
        host.access(1'b0, sel, d, 0, r, ok);
        finish_access(ok);
    endtask

    task automatic rd(input logic [1:0] sel, input logic [7:0] exp);
        logic [7:0] r;
        logic       ok;
        host.access(1'b1, sel, 8'h00, 0, r, ok);
        finish_access(ok);
        check(r, exp);
    endtask

    task automatic aborted_write(input logic [7:0] d);
        logic [7:0] r;
        logic       ok;
        host.access(1'b0, SEL_DATA, d, 1, r, ok);
        finish_access(ok);
    endtask

    task automatic pulse_reset(input int cycles);
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (cycles) @(posedge clk_sys);
        resetn <= 1'b1;
    endtask

    task automatic clock_half_period;
        int   n;
        logic prev;
        n = 0;
        prev = mgmt_serial_clock;
        while (mgmt_serial_clock === prev && n < 20)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 20)
        begin
            check(8'(n), 8'(MCLK_HALF_CYC));
            end_of_test();
        end
        n = 0;
        prev = mgmt_serial_clock;
        while (mgmt_serial_clock === prev && n < 20)
        begin
            @(posedge clk_sys);
            n++;
        end
        check(8'(n), 8'(MCLK_HALF_CYC));
        if (n >= 20)
            end_of_test();
    endtask

    task automatic point(input logic [7:0] lo);
        wr(SEL_ADDR_LO, lo);
        wr(SEL_ADDR_HI, 8'h00);
    endtask

    initial
    begin
        resetn = 1'b0;
        errors = 0;
        total_checks = 0;
        // power-up hold shortened to 20 cycles for the run
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        check({host_ready_oe, host_bus_oe, mgmt_serial_clock_oe, mgmt_data_oe,
               mgmt_phy_reset_oe, eeprom_data_oe, 2'b00}, 8'h00);
        clock_half_period();
        $display("test reset_state done");

        point(8'h05);
        wr(SEL_DATA, 8'h5A);
        rd(SEL_DATA, 8'h5A);
        rd(SEL_ADDR_LO, 8'h05);
        rd(SEL_ADDR_HI, 8'h00);
        aborted_write(8'hC3);
        rd(SEL_DATA, 8'h5A);
        $display("test basic_access done");

        point(8'h02);
        for (i = 1; i <= 2; i++)
            wr(SEL_DATA_INC, 8'(8'h11 * i));
        wr(SEL_ADDR_LO, 8'h02);
        for (i = 1; i <= 2; i++)
            rd(SEL_DATA_INC, 8'(8'h11 * i));
        rd(SEL_ADDR_LO, 8'h04);
        wr(SEL_ADDR_LO, 8'hFF);
        rd(SEL_DATA_INC, 8'h00);
        rd(SEL_ADDR_LO, 8'h00);
        rd(SEL_ADDR_HI, 8'h01);
        $display("test auto_increment done");

        point({4'h0, CTRL_IDX});
        wr(SEL_DATA, 8'h0F);
        repeat (2) @(posedge clk_sys);
        check({3'h0, mgmt_serial_clock_oe, mgmt_data_oe, mgmt_data_out,
               mgmt_phy_reset_oe, mgmt_phy_reset}, 8'h1F);
        clock_half_period();
        wr(SEL_DATA, 8'h0E);
        repeat (2) @(posedge clk_sys);
        check({5'h00, mgmt_serial_clock_oe, mgmt_data_oe, mgmt_phy_reset_oe}, 8'h00);
        wr(SEL_DATA, 8'h60);
        repeat (2) @(posedge clk_sys);
        check({5'h00, eeprom_clock, eeprom_data_oe, eeprom_data_out}, 8'h06);
        rd(SEL_DATA, 8'h70);
        wr(SEL_DATA, 8'h20);
        rd(SEL_DATA, 8'hB0);
        $display("test serial_pins done");

        wr(SEL_ADDR_HI, HW_RESET_CMD);
        rd(SEL_ADDR_HI, 8'h00);
        rd(SEL_ADDR_LO, 8'h00);
        point(8'h05);
        rd(SEL_DATA, 8'h00);
        $display("test soft_reset done");

        wr(SEL_DATA, 8'hA5);
        rd(SEL_DATA, 8'hA5);
        pulse_reset(RESET_MIN_CYC);
        point(8'h05);
        rd(SEL_DATA, 8'h00);
        point({4'h0, CTRL_IDX});
        rd(SEL_DATA, 8'h90);
        $display("test reset_pulse done");
        end_of_test();
    end
endmodule
`default_nettype wire
